// ---- verilog/ppid_pkg.sv ----
package ppid_pkg;

  // ****************************************
  // Data and field widths
  // ****************************************
  localparam int DATA_W = 16;
  localparam int GAIN_W = 10;
  localparam int ADDR_W = 8;
  localparam int RESID_W = 24;
  localparam int SET_COUNT = 3;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] REG_REF_SOURCE = 8'h00;
  localparam logic [7:0] REG_SET_SELECT = 8'h04;
  localparam logic [7:0] REG_EXT_CONTROL = 8'h08;
  localparam logic [7:0] REG_EXT_SETPOINT = 8'h0C;
  localparam logic [7:0] REG_SET_BASE = 8'h10;
  localparam logic [7:0] REG_SET_STRIDE = 8'h08;
  localparam logic [7:0] REG_ITIME_OFS = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_PROC_OUT = 8'h2C;
  localparam logic [7:0] REG_EXT_OUT = 8'h30;
  localparam logic [7:0] REG_PROC_ERROR = 8'h34;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int EXT_MODE_BIT = 0;
  localparam int EXT_ENABLE_BIT = 1;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_SET_BIT = 1;
  localparam int STAT_MODE_BIT = 2;
  localparam int STAT_EXT_EN_BIT = 3;

  // ****************************************
  // Values and reset values
  // ****************************************
  // Reference source code that hands speed to the loop (decimal 19)
  localparam logic [7:0] REF_SOURCE_LOOP = 8'h13;
  localparam logic [7:0] REF_SOURCE_RESET = 8'h00;
  // Gain in tenths: 0.1 .. 100
  localparam logic [9:0] GAIN_MIN = 10'h001;
  localparam logic [9:0] GAIN_MAX = 10'h3E8;
  localparam logic [9:0] GAIN_RESET = 10'h001;
  localparam int GAIN_DIV = 10;
  // Integration time in tenths of a second, 0 disables the integral
  localparam logic [15:0] ITIME_MAX = 16'h8CA0;
  localparam logic [15:0] ITIME_RESET = 16'h00C8;
  localparam logic [15:0] ITIME_OFF = 16'h0000;
  // Signal scale: 10000 counts equal 100 %
  localparam logic signed [15:0] OUT_MAX = 16'sh2710;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int UPDATE_PERIOD_US = 1000;
  localparam int UPDATE_CYCLES = UPDATE_PERIOD_US * CLK_MHZ;
  localparam int ITIME_UNIT_US = 100000;
  localparam int ITIME_SCALE = ITIME_UNIT_US / UPDATE_PERIOD_US;

  // ****************************************
  // Modes
  // ****************************************
  typedef enum logic {
    SET_PRIMARY = 1'b0,
    SET_SECONDARY = 1'b1
  } ppid_set_e;

  typedef enum logic {
    EXT_FIELD = 1'b0,
    EXT_TRIM = 1'b1
  } ppid_ext_mode_e;

  function automatic logic signed [15:0] ppid_sat(input logic signed [31:0] v);
    if (v > 32'(OUT_MAX)) begin
      return OUT_MAX;
    end else if (v < -32'(OUT_MAX)) begin
      return -OUT_MAX;
    end
    return v[15:0];
  endfunction : ppid_sat

endpackage : ppid_pkg

// ---- verilog/ppid_pi_core.sv ----
`timescale 1ns/1ns
module ppid_pi_core
  import ppid_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic tick,
  input wire logic signed [15:0] setpoint,
  input wire logic signed [15:0] feedback,
  input wire logic [9:0] gain,
  input wire logic [15:0] itime,
  output logic signed [15:0] ctrl_out,
  output logic signed [15:0] err_out
);

  typedef struct packed {
    logic signed [15:0] err;
    logic signed [15:0] integ;
    logic signed [23:0] resid;
    logic signed [15:0] out;
  } ppid_core_s;

  ppid_core_s st;
  ppid_core_s next_st;
  logic signed [15:0] err_now;
  logic signed [23:0] divisor;
  logic signed [31:0] prod;

  always_comb begin
    next_st = st;
    divisor = signed'(24'(itime) * 24'(ITIME_SCALE));
    err_now = ppid_sat(32'(setpoint) - 32'(feedback));
    prod = (32'(err_now) + 32'(st.integ)) * 32'(signed'({1'b0, gain}));
    if (!enable) begin
      next_st = '0;
    end else begin
      if (tick) begin
        next_st.err = err_now;
        next_st.resid = st.resid + 24'(err_now);
        next_st.out = ppid_sat(prod / GAIN_DIV);
      end else if (st.resid >= divisor) begin
        // one count per divisor of error sum
        if (st.integ < OUT_MAX) begin
          next_st.integ = st.integ + 16'sh0001;
          next_st.resid = st.resid - divisor;
        end else begin
          next_st.resid = '0;
        end
      end else if (st.resid <= -divisor) begin
        if (st.integ > -OUT_MAX) begin
          next_st.integ = st.integ - 16'sh0001;
          next_st.resid = st.resid + divisor;
        end else begin
          next_st.resid = '0;
        end
      end
      if (itime == ITIME_OFF) begin
        next_st.integ = '0;
        next_st.resid = '0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ctrl_out = st.out;
  assign err_out = st.err;

  // ****************************************
  // Checks
  // ****************************************
  sequence update_s;
    enable && tick;
  endsequence

  chk_error_diff: assert property (@(posedge core_clk) disable iff (sys_rst)
    update_s |=> err_out == ppid_sat(32'($past(setpoint)) - 32'($past(feedback))))
    else $error("error is not setpoint minus feedback");

  chk_integ_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    (itime == ITIME_OFF) |=> st.integ == 16'sh0000 && st.resid == 24'sh00_0000)
    else $error("integral active with zero integration time");

  chk_integ_step: assert property (@(posedge core_clk) disable iff (sys_rst)
    (enable && !tick && itime != ITIME_OFF && st.resid >= divisor && st.integ < OUT_MAX)
      |=> st.integ == $past(st.integ) + 16'sh0001)
    else $error("integral did not step up");

  chk_out_gain: assert property (@(posedge core_clk) disable iff (sys_rst)
    (update_s and (st.integ == 16'sh0000) and (itime == ITIME_OFF))
      |=> ctrl_out == ppid_sat(32'(err_out) * 32'(signed'({1'b0, $past(gain)})) / GAIN_DIV))
    else $error("output is not gain times error");

  chk_disable_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    !enable |=> ctrl_out == 16'sh0000 && st.integ == 16'sh0000)
    else $error("disabled controller holds state");

endmodule : ppid_pi_core

// ---- verilog/ppid_controller.sv ----
// Summary of operation
// - Error is setpoint minus feedback; output drives speed toward convergence.
// - Loop control runs only while the reference source register holds 19.
// - Two independent controllers: process loop and external trim, each with parameters.
// - Process loop has two parameter sets chosen by the set select register.
// - External mode 0, the default, drives the field instrument output.
// - External mode 1 adds the external output as trim to drive speed.
// - Gain 0.1 to 100; output change equals gain times error change.
// - Constant full error, gain 1: output rises by error in one integration time.
// - Integration time zero disables the integral part completely.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
module ppid_controller
  import ppid_pkg::*;
#(
  parameter int UPDATE_CYCLES_P = UPDATE_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata,
  input wire logic signed [15:0] process_setpoint,
  input wire logic signed [15:0] process_feedback,
  input wire logic signed [15:0] ext_feedback,
  input wire logic signed [15:0] direct_speed_ref,
  output logic signed [15:0] speed_ref,
  output logic signed [15:0] instrument_out,
  output logic loop_active
);

  localparam int CNT_W = $clog2(UPDATE_CYCLES_P);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] ref_source;
    ppid_set_e set_sel;
    ppid_ext_mode_e ext_mode;
    logic ext_enable;
    logic signed [15:0] ext_setpoint;
    logic [SET_COUNT-1:0][9:0] gain;
    logic [SET_COUNT-1:0][15:0] itime;
    logic [CNT_W-1:0] tick_cnt;
    logic tick;
    logic [15:0] rdata;
    logic signed [15:0] speed;
    logic signed [15:0] instr;
    logic active;
  } ppid_top_s;

  ppid_top_s st;
  ppid_top_s next_st;
  logic signed [15:0] proc_out;
  logic signed [15:0] proc_err;
  logic signed [15:0] ext_out;
  logic [9:0] proc_gain;
  logic [15:0] proc_itime;
  logic proc_enable;

  function automatic logic [9:0] clamp_gain(input logic [15:0] v);
    if (v < 16'(GAIN_MIN)) begin
      return GAIN_MIN;
    end else if (v > 16'(GAIN_MAX)) begin
      return GAIN_MAX;
    end
    return v[9:0];
  endfunction : clamp_gain

  function automatic logic [15:0] clamp_itime(input logic [15:0] v);
    return (v > ITIME_MAX) ? ITIME_MAX : v;
  endfunction : clamp_itime

  // ****************************************
  // Parameter set selection
  // ****************************************
  // selected set feeds process loop
  assign proc_gain = (st.set_sel == SET_SECONDARY) ? st.gain[1] : st.gain[0];
  assign proc_itime = (st.set_sel == SET_SECONDARY) ? st.itime[1] : st.itime[0];
  // loop runs only on code 19
  assign proc_enable = st.active;

  // ****************************************
  // Controllers
  // ****************************************
  // process loop controller
  ppid_pi_core u_process_loop_controller (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .enable(proc_enable),
    .tick(st.tick),
    .setpoint(process_setpoint),
    .feedback(process_feedback),
    .gain(proc_gain),
    .itime(proc_itime),
    .ctrl_out(proc_out),
    .err_out(proc_err)
  );

  ppid_pi_core u_external_trim_controller (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .enable(st.ext_enable),
    .tick(st.tick),
    .setpoint(st.ext_setpoint),
    .feedback(ext_feedback),
    .gain(st.gain[2]),
    .itime(st.itime[2]),
    .ctrl_out(ext_out),
    .err_out()
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    // Update tick: one cycle per update period
    if (st.tick_cnt == CNT_W'(UPDATE_CYCLES_P - 1)) begin
      next_st.tick_cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 1'b1;
      next_st.tick = 1'b0;
    end

    if (reg_we) begin
      case (reg_addr)
        REG_REF_SOURCE: begin
          next_st.ref_source = reg_wdata[7:0];
        end
        REG_SET_SELECT: begin
          next_st.set_sel = ppid_set_e'(reg_wdata[0]);
        end
        REG_EXT_CONTROL: begin
          next_st.ext_mode = ppid_ext_mode_e'(reg_wdata[EXT_MODE_BIT]);
          next_st.ext_enable = reg_wdata[EXT_ENABLE_BIT];
        end
        REG_EXT_SETPOINT: begin
          next_st.ext_setpoint = reg_wdata;
        end
        default: begin
        end
      endcase
      for (int i = 0; i < SET_COUNT; i++) begin
        // gain held within 0.1 .. 100
        if (reg_addr == 8'(REG_SET_BASE + REG_SET_STRIDE * 8'(i))) begin
          next_st.gain[i] = clamp_gain(reg_wdata);
        end
        if (reg_addr == 8'(REG_SET_BASE + REG_SET_STRIDE * 8'(i) + REG_ITIME_OFS)) begin
          next_st.itime[i] = clamp_itime(reg_wdata);
        end
      end
    end

    // Read data stand for one cycle only
    next_st.rdata = '0;
    if (reg_re) begin
      case (reg_addr)
        REG_REF_SOURCE: begin
          next_st.rdata = {8'h00, st.ref_source};
        end
        REG_SET_SELECT: begin
          next_st.rdata = {15'h0000, st.set_sel};
        end
        REG_EXT_CONTROL: begin
          next_st.rdata = {14'h0000, st.ext_enable, st.ext_mode};
        end
        REG_EXT_SETPOINT: begin
          next_st.rdata = st.ext_setpoint;
        end
        REG_STATUS: begin
          next_st.rdata = {12'h000, st.ext_enable, st.ext_mode, st.set_sel, st.active};
        end
        REG_PROC_OUT: begin
          next_st.rdata = proc_out;
        end
        REG_EXT_OUT: begin
          next_st.rdata = ext_out;
        end
        REG_PROC_ERROR: begin
          next_st.rdata = proc_err;
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
      for (int i = 0; i < SET_COUNT; i++) begin
        if (reg_addr == 8'(REG_SET_BASE + REG_SET_STRIDE * 8'(i))) begin
          next_st.rdata = {6'h00, st.gain[i]};
        end
        if (reg_addr == 8'(REG_SET_BASE + REG_SET_STRIDE * 8'(i) + REG_ITIME_OFS)) begin
          next_st.rdata = st.itime[i];
        end
      end
    end

    next_st.active = (st.ref_source == REF_SOURCE_LOOP);

    if (st.active) begin
      next_st.speed = proc_out;
    end else begin
      next_st.speed = direct_speed_ref;
    end
    // trim added to main speed path
    if (st.ext_enable && st.ext_mode == EXT_TRIM) begin
      next_st.speed = ppid_sat(32'(next_st.speed) + 32'(ext_out));
    end
    if (st.ext_enable && st.ext_mode == EXT_FIELD) begin
      next_st.instr = ext_out;
    end else begin
      next_st.instr = '0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
      st.ref_source <= REF_SOURCE_RESET;
      st.set_sel <= SET_PRIMARY;
      st.ext_mode <= EXT_FIELD;
      st.gain <= {SET_COUNT{GAIN_RESET}};
      st.itime <= {SET_COUNT{ITIME_RESET}};
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign speed_ref = st.speed;
  assign instrument_out = st.instr;
  assign loop_active = st.active;

  // ****************************************
  // Checks
  // ****************************************
  sequence secondary_write_s;
    reg_we && reg_addr == REG_SET_SELECT && reg_wdata[0];
  endsequence

  sequence loop_code_s;
    reg_we && reg_addr == REG_REF_SOURCE && reg_wdata[7:0] == REF_SOURCE_LOOP;
  endsequence

  chk_set_switch: assert property (@(posedge core_clk) disable iff (sys_rst)
    secondary_write_s |=> proc_gain == st.gain[1] && proc_itime == st.itime[1])
    else $error("secondary set not applied after select write");

  chk_loop_enable: assert property (@(posedge core_clk) disable iff (sys_rst)
    loop_code_s ##1 (!reg_we) |=> loop_active)
    else $error("loop not active after code 19 written");

  chk_loop_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st.ref_source != REF_SOURCE_LOOP) |=> !loop_active && !proc_enable)
    else $error("loop active with other reference source");

  chk_field_drive: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st.ext_enable && st.ext_mode == EXT_FIELD) |=> instrument_out == $past(ext_out))
    else $error("field output does not follow external controller");

  chk_trim_sum: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st.active && st.ext_enable && st.ext_mode == EXT_TRIM)
      |=> speed_ref == ppid_sat(32'($past(proc_out)) + 32'($past(ext_out))))
    else $error("trim not added to speed reference");

  chk_gain_range: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_we && reg_addr == REG_SET_BASE && reg_wdata > 16'(GAIN_MAX)) |=> st.gain[0] == GAIN_MAX)
    else $error("gain not limited to maximum");

  chk_read_answer: assert property (@(posedge core_clk) disable iff (sys_rst)
    !reg_re |=> reg_rdata == 16'h0000)
    else $error("read data outside answer cycle");

  chk_primary_set: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_we && reg_addr == REG_SET_SELECT && !reg_wdata[0])
      |=> proc_gain == st.gain[0] && proc_itime == st.itime[0])
    else $error("primary set not applied after select write");

  chk_direct_speed: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!st.active && !(st.ext_enable && st.ext_mode == EXT_TRIM)) |=> speed_ref == $past(direct_speed_ref))
    else $error("inactive loop does not pass the direct reference");

  chk_loop_speed: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st.active && !(st.ext_enable && st.ext_mode == EXT_TRIM)) |=> speed_ref == $past(proc_out))
    else $error("active loop output does not reach speed reference");

  // Status bits checked against the state, not against the read mux
  chk_status_read: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_re && reg_addr == REG_STATUS)
      |=> reg_rdata[STAT_ACTIVE_BIT] == $past(st.active) && reg_rdata[STAT_EXT_EN_BIT] == $past(st.ext_enable))
    else $error("status read does not show loop state");

endmodule : ppid_controller

// ---- tb/ppid_plant_model.sv ----
`timescale 1ns/1ns
module ppid_plant_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic signed [15:0] speed_ref,
  input wire logic hold_en,
  input wire logic signed [15:0] hold_value,
  output logic signed [15:0] process_feedback
);
  logic signed [16:0] gap;

  assign gap = 17'(speed_ref) - 17'(process_feedback);

  // ********
  // Transducer lag
  // ********
  // feedback follows speed
  // Quarter of the gap per cycle: settles well inside one update period
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      process_feedback <= 16'sh0000;
    end else if (hold_en) begin
      process_feedback <= hold_value;
    end else begin
      process_feedback <= process_feedback + 16'(gap >>> 2);
    end
  end
endmodule : ppid_plant_model

// ---- tb/tb.sv ----
`timescale 1ns/1ns
module tb
  import ppid_pkg::*;
;
  // Short update period keeps the run small
  localparam int P = 100;
  localparam logic [7:0] ITIME_P = 8'(REG_SET_BASE + REG_ITIME_OFS);
  localparam logic [7:0] GAIN_S = 8'(REG_SET_BASE + REG_SET_STRIDE);
  localparam logic [7:0] ITIME_S = 8'(GAIN_S + REG_ITIME_OFS);
  localparam logic [7:0] GAIN_X = 8'(GAIN_S + REG_SET_STRIDE);
  localparam logic [7:0] ITIME_X = 8'(GAIN_X + REG_ITIME_OFS);

  logic core_clk;
  logic sys_rst;
  logic reg_we;
  logic reg_re;
  logic loop_active;
  logic hold_en;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] va;
  logic [15:0] vb;
  logic signed [15:0] sp;
  logic signed [15:0] fb;
  logic signed [15:0] ext_fb;
  logic signed [15:0] direct;
  logic signed [15:0] speed_ref;
  logic signed [15:0] instr_out;
  int bad_count;
  int total_checks;
  logic signed [15:0] errs [4] = '{16'sh1388, 16'sh0032, 16'sh1388, -16'sh0BB8};
  logic [15:0] gains [4] = '{16'h0001, 16'h03E8, 16'h03E8, 16'h000A};

  ppid_controller #(.UPDATE_CYCLES_P(P)) uut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .process_setpoint(sp),
    .process_feedback(fb), .ext_feedback(ext_fb), .direct_speed_ref(direct), .speed_ref(speed_ref),
    .instrument_out(instr_out), .loop_active(loop_active));

  ppid_plant_model plant (.core_clk(core_clk), .sys_rst(sys_rst), .speed_ref(speed_ref), .hold_en(hold_en),
    .hold_value(16'sh0000), .process_feedback(fb));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ********
  // Access and checking
  // ********
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_re <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    check(v, exp);
  endtask : rd_chk

  // Two cycles less: each read adds two cycles, so reads stay in tick phase
  task automatic ticks(input int n);
    repeat (n * P - 2) @(posedge core_clk);
  endtask : ticks

  function automatic logic [15:0] p_exp(input int g, input int e);
    int v;
    v = g * e / GAIN_DIV;
    v = (v > int'(OUT_MAX)) ? int'(OUT_MAX) : (v < -int'(OUT_MAX)) ? -int'(OUT_MAX) : v;
    return 16'(v);
  endfunction : p_exp

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // ********
  // Main sequence
  // ********
  initial begin
    bad_count = 0;
    total_checks = 0;
    sys_rst = 1'b1;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    sp = 16'sh0BB8;
    ext_fb = 16'sh0064;
    direct = 16'sh0100;
    hold_en = 1'b1;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (i != 13) begin
        rd_chk(8'(i * 4), (i >= 4 && i <= 9) ? (i[0] ? ITIME_RESET : {6'h00, GAIN_RESET}) : 16'h0000);
      end
    end
    @(posedge core_clk);
    #1;
    check(reg_rdata, 16'h0000);
    ticks(3);
    check(speed_ref, direct);
    rd_chk(REG_PROC_OUT, 16'h0000);
    wr(REG_STATUS, 16'hFFFF);
    rd_chk(REG_STATUS, 16'h0000);
    wr(REG_SET_BASE, 16'h0000);
    rd_chk(REG_SET_BASE, 16'h0001);
    wr(REG_SET_BASE, 16'h07D0);
    rd_chk(REG_SET_BASE, 16'h03E8);
    wr(ITIME_P, 16'hFFFF);
    rd_chk(ITIME_P, ITIME_MAX);
    wr(ITIME_P, ITIME_OFF);
    wr(REG_REF_SOURCE, 16'h0013);
    @(posedge core_clk);
    #1;
    check({15'h0000, loop_active}, 16'h0001);
    // Proportional response across the gain range, saturation included
    for (int i = 0; i < 4; i++) begin
      wr(REG_SET_BASE, gains[i]);
      sp <= errs[i];
      ticks(3);
      rd_chk(REG_PROC_OUT, p_exp(gains[i], errs[i]));
      rd_chk(REG_PROC_ERROR, errs[i]);
      check(speed_ref, p_exp(gains[i], errs[i]));
    end
    wr(GAIN_S, 16'h0014);
    wr(ITIME_S, ITIME_OFF);
    wr(REG_SET_SELECT, 16'h0001);
    sp <= 16'sh03E8;
    ticks(3);
    rd_chk(REG_PROC_OUT, 16'h07D0);
    rd_chk(REG_STATUS, 16'h0003);
    wr(REG_SET_SELECT, 16'h0000);
    wr(REG_EXT_SETPOINT, 16'h07D0);
    wr(GAIN_X, 16'h000A);
    wr(ITIME_X, ITIME_OFF);
    wr(REG_EXT_CONTROL, 16'h0002);
    ticks(3);
    check(instr_out, 16'h076C);
    check(speed_ref, 16'h03E8);
    rd_chk(REG_EXT_OUT, 16'h076C);
    wr(REG_EXT_CONTROL, 16'h0003);
    ticks(3);
    check(instr_out, 16'h0000);
    check(speed_ref, 16'h0B54);
    rd_chk(REG_STATUS, 16'h000D);
    wr(REG_REF_SOURCE, 16'h0012);
    ticks(3);
    check({15'h0000, loop_active}, 16'h0000);
    check(speed_ref, 16'h086C);
    rd_chk(REG_PROC_OUT, 16'h0000);
    wr(REG_EXT_CONTROL, 16'h0000);
    // Integral adds 100 over 100 updates, then clears when the integration time returns to zero
    wr(REG_REF_SOURCE, 16'h0013);
    wr(ITIME_P, 16'h000A);
    ticks(3);
    rd(REG_PROC_OUT, va);
    ticks(100);
    rd(REG_PROC_OUT, vb);
    check(vb - va, 16'h0064);
    wr(ITIME_P, ITIME_OFF);
    ticks(3);
    rd_chk(REG_PROC_OUT, 16'h03E8);
    // Start values, then tuned up
    wr(REG_SET_BASE, 16'h0001);
    wr(ITIME_P, 16'h00C8);
    // One update of lag makes the loop ring from gain 1.0; take half of that
    wr(REG_SET_BASE, 16'h0005);
    wr(ITIME_P, 16'h0001);
    sp <= 16'sh0190;
    hold_en <= 1'b0;
    ticks(600);
    rd(REG_PROC_ERROR, va);
    check({15'h0000, $signed(va) > -16'sh0064 && $signed(va) < 16'sh0064}, 16'h0001);
    results();
  end
endmodule : tb
